// [src/bzt_top.sv]
/*
 * bzt_top: buzzer tone generator with envelope and one-shot burst,
 * reached by software over an AHB-Lite slave port.
 * Assumes a single hclk domain; the oscillator arrives as a raw pin and
 * the buzzer pin idles high.
 */
`timescale 1ns/1ps
module bzt_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // oscillator and buzzer
  input  wire logic        low_speed_osc,
  output logic             buzzer_pin
);
  import bzt_pkg::*;

  // ***************************************************************
  // bus front end
  // ***************************************************************
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [31:0] wr_addr_r;
  logic [31:0] wr_addr_nxt;
  logic        rd_go;
  logic        wr_env;
  logic        wr_burst;
  logic        wr_freq;
  logic        wr_duty;
  logic [3:0]  wd;

  // address phase is taken when the bus is ready; hsize is not checked,
  // only whole-word transfers are expected
  always_comb begin
    rd_go       = hsel && htrans[1] && hready && !hwrite;
    wr_pend_nxt = hsel && htrans[1] && hready && hwrite;
    wr_addr_nxt = wr_pend_nxt ? haddr : wr_addr_r;
    wd          = hwdata[3:0];
    wr_env      = wr_pend_r && (wr_addr_r == ADDR_TONE_ENV);
    wr_burst    = wr_pend_r && (wr_addr_r == ADDR_BURST);
    wr_freq     = wr_pend_r && (wr_addr_r == ADDR_FREQ);
    wr_duty     = wr_pend_r && (wr_addr_r == ADDR_DUTY);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
    end
  end

  // never stalls and always answers okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ***************************************************************
  // control registers
  // ***************************************************************
  logic       out_en_r;
  logic       out_en_nxt;
  logic       env_en_r;
  logic       env_en_nxt;
  logic       env_step_r;
  logic       env_step_nxt;
  logic       os_len_r;
  logic       os_len_nxt;
  logic [2:0] freq_r;
  logic [2:0] freq_nxt;
  logic [2:0] duty_r;
  logic [2:0] duty_nxt;

  // bit 3 of burst, frequency and duty writes is dropped
  always_comb begin
    out_en_nxt   = wr_env   ? wd[BIT_OUT_EN]   : out_en_r;
    env_en_nxt   = wr_env   ? wd[BIT_ENV_EN]   : env_en_r;
    env_step_nxt = wr_env   ? wd[BIT_ENV_STEP] : env_step_r;
    os_len_nxt   = wr_burst ? wd[BIT_OS_LEN]   : os_len_r;
    freq_nxt     = wr_freq  ? wd[2:0]          : freq_r;
    duty_nxt     = wr_duty  ? wd[2:0]          : duty_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_en_r   <= RST_BIT;
      env_en_r   <= RST_BIT;
      env_step_r <= RST_BIT;
      os_len_r   <= RST_BIT;
      freq_r     <= RST_FIELD;
      duty_r     <= RST_FIELD;
    end else begin
      out_en_r   <= out_en_nxt;
      env_en_r   <= env_en_nxt;
      env_step_r <= env_step_nxt;
      os_len_r   <= os_len_nxt;
      freq_r     <= freq_nxt;
      duty_r     <= duty_nxt;
    end
  end

  // ***************************************************************
  // tone generator and 256 Hz grid
  // ***************************************************************
  bzt_tone_cfg_t tone_cfg;
  logic          osc_rise;
  logic          tone_wave;
  logic [6:0]    grid_r;
  logic [6:0]    grid_nxt;
  logic          tick256;

  // frequencies and times all follow the oscillator, whatever its rate
  always_comb begin
    tick256  = osc_rise && (grid_r == SYNC_DIV);
    grid_nxt = osc_rise ? 7'(grid_r + 7'h1) : grid_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grid_r <= 7'h0;
    end else begin
      grid_r <= grid_nxt;
    end
  end

  bzt_tone_gen u_tone (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .low_speed_osc (low_speed_osc),
    .cfg           (tone_cfg),
    .osc_rise      (osc_rise),
    .tone_wave     (tone_wave)
  );

  // ***************************************************************
  // one-shot burst
  // ***************************************************************
  bzt_burst_t bst_r;
  bzt_burst_t bst_nxt;
  logic       burst_on_r;
  logic       burst_on_nxt;
  logic [5:0] bcnt_r;
  logic [5:0] bcnt_nxt;
  logic       trig_ok;
  logic       abort_ok;

  // requests are only latched here; output changes wait for the grid
  always_comb begin
    trig_ok      = wr_burst && wd[BIT_OS_TRIG] && !out_en_r;
    abort_ok     = wr_burst && wd[BIT_OS_ABORT] && (bst_r != BZT_IDLE);
    bst_nxt      = bst_r;
    burst_on_nxt = burst_on_r;
    bcnt_nxt     = bcnt_r;
    if (tick256) begin
      unique case (bst_r)
        BZT_IDLE: begin
          burst_on_nxt = 1'b0;
        end
        BZT_ARMED: begin
          bst_nxt      = BZT_RUN;
          burst_on_nxt = 1'b1;
          bcnt_nxt     = os_len_r ? BURST_LONG : BURST_SHORT;
        end
        BZT_RUN: begin
          if (bcnt_r == 6'h0) begin
            bst_nxt      = BZT_IDLE;
            burst_on_nxt = 1'b0;
          end else begin
            bcnt_nxt = 6'(bcnt_r - 6'h1);
          end
        end
        BZT_CLOSING: begin
          bst_nxt      = BZT_IDLE;
          burst_on_nxt = 1'b0;
        end
      endcase
    end
    // a write landing on the grid tick overrides its state change, not burst_on_r or bcnt_r; abort beats trigger
    if (abort_ok) begin
      bst_nxt = BZT_CLOSING;
    end else if (trig_ok) begin
      bst_nxt = BZT_ARMED;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bst_r      <= BZT_IDLE;
      burst_on_r <= 1'b0;
      bcnt_r     <= 6'h0;
    end else begin
      bst_r      <= bst_nxt;
      burst_on_r <= burst_on_nxt;
      bcnt_r     <= bcnt_nxt;
    end
  end

  // ***************************************************************
  // digital envelope
  // ***************************************************************
  logic        out_prev_r;
  logic [2:0]  env_lvl_r;
  logic [2:0]  env_lvl_nxt;
  logic [11:0] env_cnt_r;
  logic [11:0] env_cnt_nxt;
  logic        env_restart;
  logic        tone_on;

  always_comb begin
    tone_on     = out_en_r || burst_on_r;
    // restart on enable edge, or on request while envelope or tone is on
    env_restart = (out_en_r && !out_prev_r)
               || (wr_env && wd[BIT_ENV_RST] && (env_en_r || tone_on));
    env_lvl_nxt = env_lvl_r;
    env_cnt_nxt = env_cnt_r;
    if (env_restart) begin
      env_lvl_nxt = RST_FIELD;
      env_cnt_nxt = 12'h0;
    end else if (osc_rise && env_en_r && out_en_r) begin
      if (env_cnt_r >= (env_step_r ? ENV_LONG_CNT : ENV_SHORT_CNT)) begin
        env_cnt_nxt = 12'h0;
        env_lvl_nxt = (env_lvl_r == LEVEL_MIN) ? LEVEL_MIN : 3'(env_lvl_r + 3'h1);
      end else begin
        env_cnt_nxt = 12'(env_cnt_r + 12'h1);
      end
    end
    // bursts never carry the envelope, only the chosen duty
    tone_cfg.freq  = freq_r;
    tone_cfg.level = (env_en_r && out_en_r) ? env_lvl_r : duty_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_prev_r <= 1'b0;
      env_lvl_r  <= RST_FIELD;
      env_cnt_r  <= 12'h0;
    end else begin
      out_prev_r <= out_en_r;
      env_lvl_r  <= env_lvl_nxt;
      env_cnt_r  <= env_cnt_nxt;
    end
  end

  // ***************************************************************
  // buzzer pin and read data
  // ***************************************************************
  logic        pin_r;
  logic        pin_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // the enable gates the running tone directly, so switching may leave a
  // short pulse on the pin; software must tolerate it
  always_comb begin
    pin_nxt   = tone_on ? tone_wave : 1'b1;
    rdata_nxt = rdata_r;
    if (rd_go) begin
      unique case (haddr)
        ADDR_TONE_ENV: rdata_nxt = {28'h0, env_step_nxt, 1'b0,
                                    env_en_nxt, out_en_nxt};
        ADDR_BURST:    rdata_nxt = {30'h0, bst_nxt != BZT_IDLE,
                                    os_len_nxt};
        ADDR_FREQ:     rdata_nxt = {29'h0, freq_nxt};
        ADDR_DUTY:     rdata_nxt = {29'h0, duty_nxt};
        default:       rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r   <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      pin_r   <= pin_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign buzzer_pin = pin_r;
  assign hrdata     = rdata_r;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_pin_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (!out_en_r && !burst_on_r) |=> buzzer_pin) else $error("pin not high at idle");

  a_burst_start_grid: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(burst_on_r) |-> $past(tick256)) else $error("burst started off grid");

  a_burst_stop_grid: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(burst_on_r) |-> $past(tick256)) else $error("burst stopped off grid");

  a_trig_when_on: assert property (@(posedge hclk) disable iff (!hresetn)
    (bst_r == BZT_IDLE && wr_burst && out_en_r && !wd[BIT_OS_ABORT])
      |=> bst_r == BZT_IDLE) else $error("trigger taken while output enabled");

  a_busy_covers: assert property (@(posedge hclk) disable iff (!hresetn)
    burst_on_r |-> bst_r != BZT_IDLE) else $error("burst on while status ready");

  a_abort_ends: assert property (@(posedge hclk) disable iff (!hresetn)
    (bst_r == BZT_CLOSING && tick256 && !trig_ok && !abort_ok)
      |=> !burst_on_r && bst_r == BZT_IDLE)
    else $error("abort did not end burst");

  a_env_start_max: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(out_en_r) |=> env_lvl_r == 3'h0) else $error("envelope not at maximum");

  a_env_hold_min: assert property (@(posedge hclk) disable iff (!hresetn)
    (env_lvl_r == LEVEL_MIN && !env_restart) |=> env_lvl_r == LEVEL_MIN)
    else $error("envelope left minimum level");

  a_duty_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (env_en_r && out_en_r && wr_duty) |=> tone_cfg.level == env_lvl_r)
    else $error("duty code used while envelope on");

  a_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go |=> hrdata[3] == 1'b0 || $past(haddr) == ADDR_TONE_ENV)
    else $error("unused bit three read as one");

endmodule : bzt_top

// [src/bzt_pkg.sv]
/*
 * bzt_pkg: register map, field positions, reset values, timing constants
 * and shared types of the buzzer tone generator.
 * Assumes a low-speed oscillator of nominally 32.768 kHz feeding the block.
 */
package bzt_pkg;

  // ***************************************************************
  // oscillator and timing
  // ***************************************************************
  localparam longint unsigned OSC_HZ         = 64'd32768;    // crystal, nominal
  localparam longint unsigned US_PER_S       = 64'd1000000;
  localparam longint unsigned SYNC_HZ        = 64'd256;      // burst start/stop grid
  localparam longint unsigned ENV_SHORT_US   = 64'd62500;    // 62.5 ms step
  localparam longint unsigned ENV_LONG_US    = 64'd125000;   // 125 ms step
  localparam longint unsigned BURST_SHORT_US = 64'd31250;    // 31.25 ms burst
  localparam longint unsigned BURST_LONG_US  = 64'd125000;   // 125 ms burst

  // counts in oscillator periods or in 256 Hz ticks, derived from the times
  localparam logic [6:0]  SYNC_DIV      = 7'(OSC_HZ / SYNC_HZ - 64'd1);
  localparam logic [11:0] ENV_SHORT_CNT = 12'(ENV_SHORT_US * OSC_HZ / US_PER_S - 64'd1);
  localparam logic [11:0] ENV_LONG_CNT  = 12'(ENV_LONG_US * OSC_HZ / US_PER_S - 64'd1);
  localparam logic [5:0]  BURST_SHORT   = 6'(BURST_SHORT_US * SYNC_HZ / US_PER_S - 64'd1);
  localparam logic [5:0]  BURST_LONG    = 6'(BURST_LONG_US * SYNC_HZ / US_PER_S - 64'd1);

  // ***************************************************************
  // register map (printed offsets are indices, byte address = 4 x index)
  // ***************************************************************
  localparam logic [15:0] IDX_TONE_ENV  = 16'hff6c;
  localparam logic [15:0] IDX_BURST     = 16'hff6d;
  localparam logic [15:0] IDX_FREQ      = 16'hff6e;
  localparam logic [15:0] IDX_DUTY      = 16'hff6f;
  localparam logic [31:0] ADDR_TONE_ENV = {14'h0000, IDX_TONE_ENV, 2'b00};
  localparam logic [31:0] ADDR_BURST    = {14'h0000, IDX_BURST, 2'b00};
  localparam logic [31:0] ADDR_FREQ     = {14'h0000, IDX_FREQ, 2'b00};
  localparam logic [31:0] ADDR_DUTY     = {14'h0000, IDX_DUTY, 2'b00};

  // field positions
  localparam int BIT_OUT_EN    = 0;
  localparam int BIT_ENV_EN    = 1;
  localparam int BIT_ENV_RST   = 2;
  localparam int BIT_ENV_STEP  = 3;
  localparam int BIT_OS_LEN    = 0;
  localparam int BIT_OS_TRIG   = 1;
  localparam int BIT_OS_ABORT  = 2;

  // reset values and lowest envelope level
  localparam logic       RST_BIT   = 1'b0;
  localparam logic [2:0] RST_FIELD = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h7;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic [2:0] freq;   // tone_frequency_select code
    logic [2:0] level;  // effective duty level code
  } bzt_tone_cfg_t;

  typedef enum logic [1:0] {
    BZT_IDLE,
    BZT_ARMED,
    BZT_RUN,
    BZT_CLOSING
  } bzt_burst_t;

endpackage : bzt_pkg

// [src/bzt_tone_gen.sv]
/*
 * bzt_tone_gen: synchronises the low-speed oscillator into hclk and
 * divides its half periods into the selected tone and duty.
 * Assumes low_speed_osc is asynchronous and much slower than hclk.
 */
`timescale 1ns/1ps
module bzt_tone_gen (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // oscillator pin
  input  wire logic                 low_speed_osc,
  // tone setting
  input  wire bzt_pkg::bzt_tone_cfg_t cfg,
  // results
  output logic                      osc_rise,
  output logic                      tone_wave
);
  import bzt_pkg::*;

  // ***************************************************************
  // oscillator synchroniser
  // ***************************************************************
  logic [2:0] sync_r;
  logic       osc_lvl_r;
  logic       osc_lvl_nxt;
  logic       osc_edge;

  // a change counts only once the second and third stages agree
  always_comb begin
    osc_edge    = (sync_r[1] == sync_r[2]) && (sync_r[2] != osc_lvl_r);
    osc_lvl_nxt = osc_edge ? sync_r[2] : osc_lvl_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_r    <= 3'h0;
      osc_lvl_r <= 1'b0;
    end else begin
      sync_r    <= {sync_r[1:0], low_speed_osc};
      osc_lvl_r <= osc_lvl_nxt;
    end
  end

  assign osc_rise = osc_edge && sync_r[2];

  // ***************************************************************
  // tone divider, counted in oscillator half periods
  // ***************************************************************
  logic [5:0] ph_r;
  logic [5:0] ph_nxt;
  logic [5:0] period;
  logic [5:0] active;
  logic [3:0] numer;
  logic       wave_r;
  logic       wave_nxt;

  // half periods 16/20/24/28, doubled for the upper four codes
  always_comb begin
    period   = 6'(({2'b00, cfg.freq[1:0]} << 2) + 4'h0) + 6'h10;
    period   = cfg.freq[2] ? 6'(period << 1) : period;
    numer    = cfg.freq[1] ? 4'hc : 4'h8;
    active   = 6'(numer - {1'b0, cfg.level});
    active   = cfg.freq[2] ? 6'(active << 1) : active;
    ph_nxt   = ph_r;
    if (osc_edge) begin
      ph_nxt = (ph_r >= period - 6'h1) ? 6'h0 : 6'(ph_r + 6'h1);
    end
    // low while active: a piezo between pin and supply sounds on low
    wave_nxt = !(ph_nxt < active);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r   <= 6'h0;
      wave_r <= 1'b0;  // phase 0 lies in the active part; the pin idles high elsewhere
    end else begin
      ph_r   <= ph_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign tone_wave = wave_r;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_phase_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    ph_r < 6'h38) else $error("tone phase beyond longest period");

  a_wave_duty: assert property (@(posedge hclk) disable iff (!hresetn)
    (ph_r == 6'h0) |-> !wave_r) else $error("tone not active at period start");

endmodule : bzt_tone_gen

// [testbench/bzt_buzzer_model.sv]
/*
 * bzt_buzzer_model: piezo on the buzzer pin; measures the tone it hears.
 * Assumes the pin idles high and its active part is low, all in hclk.
 */
`timescale 1ns/1ps
module bzt_buzzer_model (
  // clock
  input  wire logic        hclk,
  // buzzer pin
  input  wire logic        buzzer_pin,
  // last period, last low phase and count of falls, in hclk cycles
  output logic [15:0]      period,
  output logic [15:0]      low_len,
  output logic [15:0]      n_falls
);
  logic [15:0] since_fall;
  logic        pin_d;

  initial begin
    period     = 16'h0;
    low_len    = 16'h0;
    n_falls    = 16'h0;
    since_fall = 16'h0;
    pin_d      = 1'b1;
  end

  // every edge counts, so a switch-on glitch just gives one odd sample
  always @(posedge hclk) begin
    since_fall <= since_fall + 16'h1;
    if (pin_d && !buzzer_pin) begin
      period     <= since_fall + 16'h1;
      since_fall <= 16'h0;
      n_falls    <= n_falls + 16'h1;
    end
    if (!pin_d && buzzer_pin) begin
      low_len <= since_fall + 16'h1;
    end
    pin_d <= buzzer_pin;
  end
endmodule : bzt_buzzer_model

// [testbench/bzt_top_tb.sv]
/*
 * bzt_top_tb: register, tone, envelope and burst tests of bzt_top.
 * Assumes a stand-in oscillator of 6 hclk per period, so every time that
 * counts oscillator periods shrinks by the same factor.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module bzt_top_tb;
  import bzt_pkg::*;
  localparam int OP = 6;        // hclk per oscillator period
  localparam int TK = 128 * OP; // one 256 hz grid tick

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        osc     = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        buzzer_pin;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] m_per;
  logic [15:0] m_low;
  logic [15:0] m_falls;
  int          fails    = 0;
  int          n_checks = 0;
  int          cyc      = 0;
  int          t0;

  always #2.5 hclk = ~hclk;
  // free-running, toggles on hclk falling edges, away from rising edges
  always #15 osc = ~osc;

  bzt_top i_bzt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_speed_osc(osc),
    .buzzer_pin(buzzer_pin));
  bzt_buzzer_model i_bzt_buzzer_model (.hclk(hclk), .buzzer_pin(buzzer_pin),
    .period(m_per), .low_len(m_low), .n_falls(m_falls));

  // ***************************************************************
  // tasks
  // ***************************************************************
  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  // skip two falls so a config change or glitch has settled
  task automatic tone_chk(input logic [15:0] p, input logic [15:0] l);
    logic [15:0] n;
    n = m_falls + 16'h3;
    while (m_falls !== n) @(posedge hclk);
    @(negedge hclk);
    `CHK(m_per, p)
    `CHK(m_low, l)
  endtask : tone_chk

  // poll busy until ready; elapsed cycles since t0 must fall in [lo, hi]
  task automatic idle_in(input int lo, input int hi);
    do bus(1'b0, ADDR_BURST, 32'h0); while (rd[1] === 1'b1);
    `CHK(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1)
    // the pin follows the off tick one register later than the status
    repeat (2) @(posedge hclk);
    `CHK(buzzer_pin, 1'b1)
  endtask : idle_in

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // cycle count and hang guard; the run needs about 60k cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      finish_test();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    logic [15:0] n;
    int hp;
    int lo;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK(buzzer_pin, 1'b1)
    for (int i = 0; i < 4; i++) rchk(ADDR_TONE_ENV + 32'(4 * i), 32'h0);
    bus(1'b1, ADDR_DUTY + 32'h4, 32'hf);
    rchk(ADDR_DUTY + 32'h4, 32'h0);
    bus(1'b1, ADDR_BURST, 32'h8);
    rchk(ADDR_BURST, 32'h0);
    bus(1'b1, ADDR_FREQ, 32'hf);
    rchk(ADDR_FREQ, 32'h7);
    bus(1'b1, ADDR_DUTY, 32'hf);
    rchk(ADDR_DUTY, 32'h7);
    bus(1'b1, ADDR_TONE_ENV, 32'hf);
    rchk(ADDR_TONE_ENV, 32'hb);
    // every frequency code, each with its own duty code
    bus(1'b1, ADDR_TONE_ENV, 32'h1);
    for (int f = 0; f < 8; f++) begin
      bus(1'b1, ADDR_FREQ, 32'(f));
      bus(1'b1, ADDR_DUTY, 32'(f));
      hp = 3 * ((16 + 4 * (f % 4)) << (f / 4));
      lo = 3 * (((f % 4 > 1 ? 12 : 8) - f) << (f / 4));
      tone_chk(16'(hp), 16'(lo));
    end
    // envelope overrides the duty code; a long step outlasts a short one
    bus(1'b1, ADDR_FREQ, 32'h0);
    bus(1'b1, ADDR_TONE_ENV, 32'h0);
    bus(1'b1, ADDR_TONE_ENV, 32'hb);
    bus(1'b1, ADDR_DUTY, 32'h5);
    tone_chk(16'h30, 16'h18);
    repeat (2048 * OP) @(posedge hclk);
    tone_chk(16'h30, 16'h18);
    bus(1'b1, ADDR_TONE_ENV, 32'h3);
    tone_chk(16'h30, 16'h15);
    bus(1'b1, ADDR_TONE_ENV, 32'h7);
    tone_chk(16'h30, 16'h18);
    rchk(ADDR_TONE_ENV, 32'h3);
    bus(1'b1, ADDR_TONE_ENV, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK(buzzer_pin, 1'b1)
    // short burst on the tick grid
    n = m_falls;
    t0 = cyc;
    bus(1'b1, ADDR_BURST, 32'h2);
    rchk(ADDR_BURST, 32'h2);
    idle_in(8 * TK, 9 * TK + 16);
    `CHK(m_falls !== n, 1'b1)
    // retrigger halfway extends to a full length from the new write
    bus(1'b1, ADDR_BURST, 32'h2);
    repeat (4 * TK) @(posedge hclk);
    t0 = cyc;
    bus(1'b1, ADDR_BURST, 32'h2);
    idle_in(8 * TK, 9 * TK + 16);
    // early stop, then a stop while idle
    bus(1'b1, ADDR_BURST, 32'h2);
    repeat (2 * TK) @(posedge hclk);
    t0 = cyc;
    bus(1'b1, ADDR_BURST, 32'h4);
    idle_in(0, TK + 16);
    bus(1'b1, ADDR_BURST, 32'h4);
    rchk(ADDR_BURST, 32'h0);
    // trigger refused while continuous output is on
    bus(1'b1, ADDR_TONE_ENV, 32'h1);
    bus(1'b1, ADDR_BURST, 32'h2);
    rchk(ADDR_BURST, 32'h0);
    bus(1'b1, ADDR_TONE_ENV, 32'h0);
    // long burst
    t0 = cyc;
    bus(1'b1, ADDR_BURST, 32'h3);
    idle_in(32 * TK, 33 * TK + 16);
    rchk(ADDR_BURST, 32'h1);
    finish_test();
  end
endmodule : bzt_top_tb
